// ### pkg/tlm_pkg.sv
// Constants for the T1 line monitor and maintenance block
package tlm_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_DECODER = 8'h28;
  localparam logic [7:0] IDX_LOSS_THR = 8'h29;
  localparam logic [7:0] IDX_SLICER_PEAK = 8'h2A;
  localparam logic [7:0] IDX_LOOPBACK = 8'h2B;
  localparam logic [7:0] IDX_LOSS_ONES = 8'h2C;
  localparam logic [7:0] IDX_ERR_CTRL = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h36;
  localparam logic [7:0] IDX_CNT_LO = 8'h3C;
  localparam logic [7:0] IDX_CNT_HI = 8'h3D;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_DECODER = 8'h00;
  localparam logic [7:0] RST_LOSS_THR = 8'h15;
  localparam logic [7:0] RST_SLICER_PEAK = 8'h18;
  localparam logic [7:0] RST_LOOPBACK = 8'h00;
  localparam logic [7:0] RST_LOSS_ONES = 8'h00;
  localparam logic [7:0] RST_ERR_CTRL = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_DECODER = 0;
  localparam int BIT_LONG_HAUL = 6;
  localparam int BIT_LOSS_CRIT = 2;
  localparam int BIT_RX_ONES = 1;
  localparam int BIT_TX_ONES = 0;
  localparam int BIT_VIOL = 6;
  localparam int BIT_EXZ_CRIT = 4;
  localparam int BIT_EXZ_SEL = 2;
  localparam int BIT_REPORT_MODE = 1;
  localparam int BIT_XFER = 0;
  localparam int BIT_SLICER = 4;
  localparam int BIT_WINDOW = 2;
  localparam logic [1:0] EXZ_COUNT_ON = 2'h1;
  // ****************************************
  // Loss of signal and excess zero figures
  // ****************************************
  localparam logic [5:0] Q_BASE_DB = 6'h04;
  localparam logic [4:0] Q_LAST_CODE = 5'h16;
  localparam logic [5:0] Q_MAX_DB = 6'h30;
  localparam logic [5:0] HYST_DB = 6'h04;
  localparam logic [11:0] SH_DECLARE_MVPP = 12'h320;
  localparam logic [11:0] SH_CLEAR_MVPP = 12'h3E8;
  localparam logic [10:0] DECLARE_BITS_T1 = 11'h0AF;
  localparam logic [10:0] DECLARE_BITS_I431 = 11'h608;
  localparam logic [6:0] CLEAR_WINDOW_LAST = 7'h7F;
  localparam logic [7:0] CLEAR_MIN_MARKS = 8'h10;
  localparam logic [7:0] CLEAR_MAX_ZEROS = 8'h64;
  localparam logic [6:0] EXZ_B8ZS = 7'h07;
  localparam logic [6:0] EXZ_AMI_ANSI = 7'h0F;
  localparam logic [6:0] EXZ_AMI_FCC = 7'h50;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam longint ONE_SEC_NS = 1000000000;
  localparam int ONE_SEC_CYCLES = int'(ONE_SEC_NS / CLK_PERIOD_NS);
endpackage

// ### rtl/tlm_top.sv
// T1 receive line monitor and maintenance controls behind an AXI4-Lite slave
// Functional notes
// RL1: long haul declare level -4 dB minus 2 dB/code; codes above 22 give -48 dB
// RL2: short haul ignores threshold field, fixed levels
// RL3: slicer field picks 40/50/60/70 percent
// RL4: peak window field picks 32 to 256 bits
// RL5: monitor gain 0 dB or 22 dB
// RL6: six loopback enables each drive one path
// RL7: criterion 0 declares after 175 low bits
// RL8: criterion 1 declares after 1544 low bits
// RL9: clear needs level, density, zero run in 128
// RL10: clear level Q+4 dB or 1 Vpp
// RL11: receive all ones on loss when enabled
// RL12: transmit all ones on loss when enabled
// RL13: rising trigger inserts exactly one violation
// RL14: criterion 0: AMI over 15, B8ZS over 7
// RL15: criterion 1: AMI over 80, B8ZS over 7
// RL16: count excess zeros only when select is 01
// RL17: manual mode copies counter on trigger rise
// RL18: auto mode copies counter every second
// RL19: software toggles trigger; manual mode only
// RL20: decoder bit 0 B8ZS, 1 AMI
// RL21: status bit shows loss of signal
// RL22: counter saturates, restarts after each copy
`timescale 1ns/1ps
module tlm_top #(
  parameter int ONE_SEC_CYC = tlm_pkg::ONE_SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive line: one bit per rx_bit_valid, analog level measurements
  input wire logic rx_bit_valid,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  input wire logic [5:0] rx_atten_db,
  input wire logic [11:0] rx_peak_mvpp,
  // Receive data towards the framer
  output logic rx_data,
  // Transmit stream from the framer and towards the line
  input wire logic tx_bit_valid,
  input wire logic tx_pos_in,
  input wire logic tx_neg_in,
  output logic tx_pos,
  output logic tx_neg,
  // Analog front end controls
  output logic [5:0] loss_declare_db,
  output logic [1:0] slicer_threshold_sel,
  output logic [1:0] peak_window_sel,
  output logic [1:0] monitor_gain_sel,
  output logic [5:0] loop_en,
  output logic signal_loss_status
);
  import tlm_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] decoder_r, loss_thr_r, slicer_peak_r, loopback_r, loss_ones_r, err_ctrl_r;
  logic [15:0] cnt_report_r;
  logic [15:0] exz_cnt_r;
  logic loss_r;
  logic aw_hold_r, w_hold_r;
  logic [7:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;

  logic long_haul, rx_decoder_sel, loss_criterion_sel;
  logic exz_criterion, report_mode, xfer_trig, viol_trig;
  logic [1:0] exz_count_sel;
  assign rx_decoder_sel = decoder_r[BIT_DECODER];
  assign long_haul = loss_thr_r[BIT_LONG_HAUL];
  assign loss_criterion_sel = loss_ones_r[BIT_LOSS_CRIT];
  assign exz_criterion = err_ctrl_r[BIT_EXZ_CRIT];
  assign exz_count_sel = err_ctrl_r[BIT_EXZ_SEL +: 2];
  assign report_mode = err_ctrl_r[BIT_REPORT_MODE];
  assign xfer_trig = err_ctrl_r[BIT_XFER];
  assign viol_trig = err_ctrl_r[BIT_VIOL];

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_take, w_take, wr_go;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_idx_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_r && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_hold_r && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[9:2];
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped(aw_idx_r) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_mapped(input logic [7:0] idx);
    wr_mapped = idx == IDX_DECODER || idx == IDX_LOSS_THR || idx == IDX_SLICER_PEAK ||
                idx == IDX_LOOPBACK || idx == IDX_LOSS_ONES || idx == IDX_ERR_CTRL;
  endfunction

  logic wr_en;
  assign wr_en = wr_go && wstrb0_r;

  // Control registers; reserved bits are masked to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decoder_r <= RST_DECODER;
      loss_thr_r <= RST_LOSS_THR;
      slicer_peak_r <= RST_SLICER_PEAK;
      loopback_r <= RST_LOOPBACK;
      loss_ones_r <= RST_LOSS_ONES;
      err_ctrl_r <= RST_ERR_CTRL;
    end else if (wr_en) begin
      unique case (aw_idx_r)
        IDX_DECODER: decoder_r <= wdata_r[7:0] & 8'h11;
        IDX_LOSS_THR: loss_thr_r <= wdata_r[7:0] & 8'h5F;
        IDX_SLICER_PEAK: slicer_peak_r <= wdata_r[7:0] & 8'h3F;
        IDX_LOOPBACK: loopback_r <= wdata_r[7:0] & 8'h77;
        IDX_LOSS_ONES: loss_ones_r <= wdata_r[7:0] & 8'h07;
        IDX_ERR_CTRL: err_ctrl_r <= wdata_r[7:0] & 8'h5F;
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic [7:0] rd_byte;
  logic rd_ok;
  always_comb begin
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[9:2])
      IDX_DECODER: rd_byte = decoder_r;
      IDX_LOSS_THR: rd_byte = loss_thr_r;
      IDX_SLICER_PEAK: rd_byte = slicer_peak_r;
      IDX_LOOPBACK: rd_byte = loopback_r;
      IDX_LOSS_ONES: rd_byte = loss_ones_r;
      IDX_ERR_CTRL: rd_byte = err_ctrl_r;
      IDX_STATUS: rd_byte = {7'h00, loss_r}; // RL21
      IDX_CNT_LO: rd_byte = cnt_report_r[7:0];
      IDX_CNT_HI: rd_byte = cnt_report_r[15:8];
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Front end controls
  // ****************************************
  logic [5:0] q_db;
  assign q_db = (loss_thr_r[4:0] >= Q_LAST_CODE) ? Q_MAX_DB :
                6'(Q_BASE_DB + {loss_thr_r[4:0], 1'b0}); // RL1

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_declare_db <= 6'h00;
      slicer_threshold_sel <= 2'h0;
      peak_window_sel <= 2'h0;
      monitor_gain_sel <= 2'h0;
      loop_en <= 6'h00;
    end else begin
      loss_declare_db <= q_db; // RL1
      slicer_threshold_sel <= slicer_peak_r[BIT_SLICER +: 2]; // RL3
      peak_window_sel <= slicer_peak_r[BIT_WINDOW +: 2]; // RL4
      monitor_gain_sel <= slicer_peak_r[1:0]; // RL5
      loop_en <= {loopback_r[6:4], loopback_r[2:0]}; // RL6
    end
  end

  // ****************************************
  // Loss of signal detection
  // ****************************************
  logic below_lvl, above_clr, rx_mark;
  logic [10:0] below_cnt_r, declare_limit;
  logic [6:0] win_cnt_r;
  logic [7:0] win_marks_r, win_zrun_r;
  assign rx_mark = rx_line_pos || rx_line_neg;
  // Short haul uses fixed levels; the threshold field is not looked at
  assign below_lvl = long_haul ? (rx_atten_db > q_db) : (rx_peak_mvpp < SH_DECLARE_MVPP); // RL2
  assign above_clr = long_haul ? ({1'b0, rx_atten_db} + {1'b0, HYST_DB} < {1'b0, q_db}) :
                     (rx_peak_mvpp > SH_CLEAR_MVPP); // RL10
  assign declare_limit = loss_criterion_sel ? DECLARE_BITS_I431 : DECLARE_BITS_T1; // RL7 RL8

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      below_cnt_r <= 11'h000;
    end else if (rx_bit_valid) begin
      below_cnt_r <= (!below_lvl || loss_r) ? 11'h000 : 11'(below_cnt_r + 11'h001);
    end
  end

  // Clear window: 128 bits above clear level with density and zero run bounds
  logic win_fail, win_done;
  assign win_fail = !above_clr || (!rx_mark && win_zrun_r + 8'h01 >= CLEAR_MAX_ZEROS);
  assign win_done = win_cnt_r == CLEAR_WINDOW_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_r <= 7'h00;
      win_marks_r <= 8'h00;
      win_zrun_r <= 8'h00;
    end else if (!loss_r || (rx_bit_valid && (win_fail || win_done))) begin
      win_cnt_r <= 7'h00;
      win_marks_r <= 8'h00;
      win_zrun_r <= 8'h00;
    end else if (rx_bit_valid) begin
      win_cnt_r <= 7'(win_cnt_r + 7'h01);
      win_marks_r <= rx_mark ? 8'(win_marks_r + 8'h01) : win_marks_r;
      win_zrun_r <= rx_mark ? 8'h00 : 8'(win_zrun_r + 8'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_r <= 1'b0;
    end else if (rx_bit_valid) begin
      if (!loss_r && below_lvl && below_cnt_r + 11'h001 >= declare_limit) begin
        loss_r <= 1'b1; // RL7 RL8
      end else if (loss_r && win_done && !win_fail &&
                   win_marks_r + (rx_mark ? 8'h01 : 8'h00) >= CLEAR_MIN_MARKS) begin
        loss_r <= 1'b0; // RL9
      end
    end
  end

  a_los_declare_count: // RL7
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(loss_r) |-> $past(below_cnt_r) == declare_limit - 11'h001)
    else $error("loss declared at wrong bit count");
  a_los_clear_window: // RL9
    assert property (@(posedge clk) disable iff (!rst_n)
      $fell(loss_r) |-> $past(win_cnt_r) == CLEAR_WINDOW_LAST && $past(above_clr))
    else $error("loss cleared outside a full window");

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      signal_loss_status <= 1'b0;
    end else begin
      signal_loss_status <= loss_r; // RL21
    end
  end

  // ****************************************
  // Receive data with all ones on loss
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 1'b0;
    end else if (rx_bit_valid) begin
      rx_data <= (loss_r && loss_ones_r[BIT_RX_ONES]) ? 1'b1 : rx_mark; // RL11
    end
  end

  a_rx_all_ones: // RL11
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_bit_valid && loss_r && loss_ones_r[BIT_RX_ONES] |=> rx_data)
    else $error("receive data not forced to ones");

  // ****************************************
  // Transmit: all ones on loss and violation insertion
  // ****************************************
  logic viol_trig_d_r, viol_pend_r, last_pol_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_trig_d_r <= 1'b0;
      viol_pend_r <= 1'b0;
      last_pol_r <= 1'b0;
      tx_pos <= 1'b0;
      tx_neg <= 1'b0;
    end else begin
      viol_trig_d_r <= viol_trig;
      if (viol_trig && !viol_trig_d_r) begin
        viol_pend_r <= 1'b1; // RL13
      end else if (tx_bit_valid) begin
        viol_pend_r <= 1'b0;
      end
      if (tx_bit_valid) begin
        if (viol_pend_r) begin
          tx_pos <= last_pol_r; // RL13
          tx_neg <= !last_pol_r;
        end else if (loss_r && loss_ones_r[BIT_TX_ONES]) begin
          tx_pos <= !last_pol_r; // RL12
          tx_neg <= last_pol_r;
          last_pol_r <= !last_pol_r;
        end else begin
          tx_pos <= tx_pos_in;
          tx_neg <= tx_neg_in;
          if (tx_pos_in ^ tx_neg_in) begin
            last_pol_r <= tx_pos_in;
          end
        end
      end
    end
  end

  a_viol_once: // RL13
    assert property (@(posedge clk) disable iff (!rst_n)
      viol_pend_r && tx_bit_valid |=> !viol_pend_r || $rose(viol_trig_d_r))
    else $error("violation issued more than once");
  a_tx_all_ones: // RL12
    assert property (@(posedge clk) disable iff (!rst_n)
      tx_bit_valid && !viol_pend_r && loss_r && loss_ones_r[BIT_TX_ONES]
      |=> tx_pos != tx_neg)
    else $error("transmit all ones missing a mark");

  // ****************************************
  // Excess zero detection and counting
  // ****************************************
  logic [6:0] zrun_r, exz_limit;
  logic exz_event, xfer_d_r, xfer_now, sec_tick;
  logic [31:0] sec_cnt_r;
  assign exz_limit = !rx_decoder_sel ? EXZ_B8ZS :
                     (exz_criterion ? EXZ_AMI_FCC : EXZ_AMI_ANSI); // RL14 RL15 RL20
  assign exz_event = rx_bit_valid && !rx_mark && zrun_r == exz_limit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zrun_r <= 7'h00;
    end else if (rx_bit_valid) begin
      zrun_r <= rx_mark ? 7'h00 : (zrun_r > exz_limit ? zrun_r : 7'(zrun_r + 7'h01));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_r <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= sec_cnt_r == 32'(ONE_SEC_CYC - 1);
      sec_cnt_r <= (sec_cnt_r == 32'(ONE_SEC_CYC - 1)) ? 32'h0000_0000 :
                   32'(sec_cnt_r + 32'h0000_0001);
    end
  end

  assign xfer_now = report_mode ? sec_tick : (xfer_trig && !xfer_d_r); // RL17 RL18 RL19

  // A same cycle event after a copy starts the next count at one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_d_r <= 1'b0;
      exz_cnt_r <= 16'h0000;
      cnt_report_r <= 16'h0000;
    end else begin
      xfer_d_r <= xfer_trig;
      if (xfer_now) begin
        cnt_report_r <= exz_cnt_r; // RL17 RL18
      end
      if (exz_event && exz_count_sel == EXZ_COUNT_ON) begin // RL16
        exz_cnt_r <= xfer_now ? 16'h0001 :
                     (&exz_cnt_r ? exz_cnt_r : 16'(exz_cnt_r + 16'h0001)); // RL22
      end else if (xfer_now) begin
        exz_cnt_r <= 16'h0000; // RL22
      end
    end
  end

  a_exz_gate: // RL16
    assert property (@(posedge clk) disable iff (!rst_n)
      exz_count_sel != EXZ_COUNT_ON && !xfer_now |=> $stable(exz_cnt_r))
    else $error("counter moved while counting disabled");
  a_exz_saturate: // RL22
    assert property (@(posedge clk) disable iff (!rst_n)
      exz_cnt_r == 16'hFFFF && !xfer_now |=> exz_cnt_r == 16'hFFFF)
    else $error("counter wrapped");
  a_manual_copy: // RL17
    assert property (@(posedge clk) disable iff (!rst_n)
      !report_mode && $rose(xfer_trig) |=> cnt_report_r == $past(exz_cnt_r))
    else $error("manual copy missing");
  a_auto_copy: // RL18
    assert property (@(posedge clk) disable iff (!rst_n)
      report_mode && sec_tick |=> cnt_report_r == $past(exz_cnt_r))
    else $error("auto copy missing");
  a_exz_limit: // RL14
    assert property (@(posedge clk) disable iff (!rst_n)
      exz_event |-> zrun_r == (!rx_decoder_sel ? 7'h07 : (exz_criterion ? 7'h50 : 7'h0F)))
    else $error("excess zero at wrong run length");

endmodule // tlm_top

// ### verif/tlm_line_model.sv
// Line and framer side model: serial bits into and out of the block
`timescale 1ns/1ps
module tlm_line_model (
  // Clock
  input wire logic clk,
  // Receive line towards the block
  output logic rx_bit_valid,
  output logic rx_line_pos,
  output logic rx_line_neg,
  output logic [5:0] rx_atten_db,
  output logic [11:0] rx_peak_mvpp,
  input wire logic rx_data,
  // Transmit stream from the framer and back from the block
  output logic tx_bit_valid,
  output logic tx_pos_in,
  output logic tx_neg_in,
  input wire logic tx_pos,
  input wire logic tx_neg
);
  logic pol = 1'b0;
  logic tpol = 1'b0;
  logic last_pos;
  initial begin
    {rx_bit_valid, rx_line_pos, rx_line_neg, tx_bit_valid, tx_pos_in, tx_neg_in} = '0;
    rx_atten_db = 6'h00;
    rx_peak_mvpp = 12'h4B0;
  end
  // ****************************************
  // Receive bits, alternate mark polarity; count ones handed on
  // ****************************************
  task automatic send_rx(input int n, input logic mark, input logic [11:0] mv, output int ones);
    ones = 0;
    repeat (n) begin
      @(posedge clk);
      rx_bit_valid <= 1'b1;
      rx_line_pos <= mark & ~pol;
      rx_line_neg <= mark & pol;
      rx_peak_mvpp <= mv;
      pol = pol ^ mark;
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      // Stale marks must not be reused between bits
      rx_line_pos <= ~rx_line_pos;
      rx_line_neg <= ~rx_line_neg;
      @(posedge clk);
      #1 ones += int'(rx_data === 1'b1);
    end
  endtask
  // ****************************************
  // Transmit bits; count marks and repeated polarities on the line
  // ****************************************
  task automatic send_tx(input int n, input logic mark, output int marks, output int viols);
    marks = 0;
    viols = 0;
    repeat (n) begin
      @(posedge clk);
      tx_bit_valid <= 1'b1;
      tx_pos_in <= mark & ~tpol;
      tx_neg_in <= mark & tpol;
      tpol = tpol ^ mark;
      @(posedge clk);
      tx_bit_valid <= 1'b0;
      @(posedge clk);
      #1 if (tx_pos === 1'b1 || tx_neg === 1'b1) begin
        marks++;
        viols += int'(tx_pos === last_pos);
        last_pos = tx_pos;
      end
    end
  endtask
endmodule // tlm_line_model

// ### verif/testbench.sv
// Self-checking bench for the T1 line monitor and maintenance block
`timescale 1ns/1ps
module testbench;
  import tlm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxd, tp, tn, los;
  logic rbv, rp, rn, tbv, tpi, tni;
  logic [1:0] bresp, rresp, slc, pw, mg;
  logic [31:0] rdata;
  logic [5:0] att, ldb, lp;
  logic [11:0] pk;
  int num_errors = 0;
  int total_checks = 0;
  tlm_top #(.ONE_SEC_CYC(200)) i_tlm_top (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_bit_valid(rbv), .rx_line_pos(rp), .rx_line_neg(rn), .rx_atten_db(att),
    .rx_peak_mvpp(pk), .rx_data(rxd), .tx_bit_valid(tbv), .tx_pos_in(tpi), .tx_neg_in(tni),
    .tx_pos(tp), .tx_neg(tn), .loss_declare_db(ldb), .slicer_threshold_sel(slc),
    .peak_window_sel(pw), .monitor_gain_sel(mg), .loop_en(lp), .signal_loss_status(los));
  tlm_line_model i_tlm_line_model (.clk(clk), .rx_bit_valid(rbv), .rx_line_pos(rp),
    .rx_line_neg(rn), .rx_atten_db(att), .rx_peak_mvpp(pk), .rx_data(rxd),
    .tx_bit_valid(tbv), .tx_pos_in(tpi), .tx_neg_in(tni), .tx_pos(tp), .tx_neg(tn));
  initial begin
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, e, "read data");
    chk(r, er, "read response");
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdc(IDX_SLICER_PEAK, 32'h18, 2'h0);
    rdc(IDX_LOOPBACK, 32'h0, 2'h0);
    rdc(IDX_LOSS_ONES, 32'h0, 2'h0);
    rdc(IDX_ERR_CTRL, 32'h0, 2'h0);
    rdc(8'h30, 32'h0, 2'h2);
    wr(IDX_STATUS, 8'h01, 2'h2);
    wr(IDX_SLICER_PEAK, 8'h39, 2'h0);
    repeat (2) @(posedge clk);
    chk(slc, 2'h3, "slicer");
    chk(pw, 2'h2, "window");
    chk(mg, 2'h1, "gain");
    wr(IDX_LOOPBACK, 8'h52, 2'h0);
    repeat (2) @(posedge clk);
    chk(lp, 6'h2A, "loops a");
    wr(IDX_LOOPBACK, 8'h25, 2'h0);
    repeat (2) @(posedge clk);
    chk(lp, 6'h15, "loops b");
    $display("registers test done");
  endtask
  task automatic t_thr();
    logic [4:0] c[5] = '{5'h00, 5'h0A, 5'h15, 5'h16, 5'h1F};
    logic [5:0] q[5] = '{6'h04, 6'h18, 6'h2E, 6'h30, 6'h30};
    for (int i = 0; i < 5; i++) begin
      wr(IDX_LOSS_THR, {3'b010, c[i]}, 2'h0);
      repeat (2) @(posedge clk);
      chk(ldb, q[i], "declare threshold");
    end
    // Short haul with the mildest code: level comes from peak only
    wr(IDX_LOSS_THR, 8'h00, 2'h0);
    $display("threshold test done");
  endtask
  task automatic t_los(input logic crit, input int n);
    int o;
    int m;
    int v;
    wr(IDX_LOSS_ONES, {5'h0, crit, 2'b11}, 2'h0);
    i_tlm_line_model.send_rx(n - 1, 1'b1, 12'h1F4, o);
    chk(los, 1'b0, "loss early");
    i_tlm_line_model.send_rx(1, 1'b1, 12'h1F4, o);
    chk(los, 1'b1, "loss declared");
    rdc(IDX_STATUS, 32'h1, 2'h0);
    i_tlm_line_model.send_rx(8, 1'b0, 12'h1F4, o);
    chk(o, 8, "rx all ones");
    i_tlm_line_model.send_tx(8, 1'b0, m, v);
    chk(m, 8, "tx all ones");
    // Two full zero runs leave the clear window empty
    i_tlm_line_model.send_rx(200, 1'b0, 12'h4B0, o);
    chk(los, 1'b1, "no marks");
    i_tlm_line_model.send_rx(120, 1'b1, 12'h4B0, o);
    chk(los, 1'b1, "short window");
    i_tlm_line_model.send_rx(10, 1'b1, 12'h4B0, o);
    chk(los, 1'b0, "loss cleared");
    i_tlm_line_model.send_rx(4, 1'b0, 12'h4B0, o);
    chk(o, 0, "no insertion");
    rdc(IDX_STATUS, 32'h0, 2'h0);
    $display("loss test done");
  endtask
  task automatic zr(input int z);
    int o;
    i_tlm_line_model.send_rx(2, 1'b1, 12'h4B0, o);
    i_tlm_line_model.send_rx(z, 1'b0, 12'h4B0, o);
    i_tlm_line_model.send_rx(1, 1'b1, 12'h4B0, o);
  endtask
  task automatic xfer(input logic [7:0] ctl, input logic [15:0] e);
    wr(IDX_ERR_CTRL, ctl, 2'h0);
    wr(IDX_ERR_CTRL, ctl | 8'h01, 2'h0);
    rdc(IDX_CNT_LO, {24'h0, e[7:0]}, 2'h0);
    rdc(IDX_CNT_HI, {24'h0, e[15:8]}, 2'h0);
  endtask
  task automatic t_exz();
    wr(IDX_ERR_CTRL, 8'h04, 2'h0);
    zr(7);
    zr(8);
    zr(8);
    xfer(8'h04, 16'h0002);
    wr(IDX_DECODER, 8'h01, 2'h0);
    zr(15);
    zr(16);
    xfer(8'h04, 16'h0001);
    wr(IDX_ERR_CTRL, 8'h14, 2'h0);
    zr(80);
    zr(81);
    xfer(8'h14, 16'h0001);
    wr(IDX_DECODER, 8'h00, 2'h0);
    zr(8);
    xfer(8'h14, 16'h0001);
    wr(IDX_ERR_CTRL, 8'h10, 2'h0);
    zr(8);
    xfer(8'h10, 16'h0000);
    $display("excess zero test done");
  endtask
  task automatic t_auto();
    logic [31:0] d;
    logic [1:0] r;
    logic seen;
    seen = 1'b0;
    wr(IDX_ERR_CTRL, 8'h06, 2'h0);
    zr(8);
    repeat (120) begin
      rd(IDX_CNT_LO, d, r);
      if (d === 32'h1) seen = 1'b1;
    end
    chk(seen, 1'b1, "auto copy");
    $display("auto report test done");
  endtask
  task automatic t_viol();
    int m;
    int v;
    i_tlm_line_model.send_tx(4, 1'b1, m, v);
    wr(IDX_ERR_CTRL, 8'h40, 2'h0);
    i_tlm_line_model.send_tx(10, 1'b0, m, v);
    chk(m, 1, "one insert");
    chk(v, 1, "same polarity");
    i_tlm_line_model.send_tx(10, 1'b0, m, v);
    chk(m, 0, "held bit");
    wr(IDX_ERR_CTRL, 8'h00, 2'h0);
    wr(IDX_ERR_CTRL, 8'h40, 2'h0);
    i_tlm_line_model.send_tx(10, 1'b0, m, v);
    chk(m, 1, "second insert");
    $display("violation test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_thr();
    t_los(1'b0, 175);
    t_los(1'b1, 1544);
    t_exz();
    t_auto();
    t_viol();
    give_verdict();
  end
endmodule // testbench
